// [dsm_ctrl.v]
// Global control, interrupt routing and pin control of the dual serial module
`timescale 1ns/10ps
`default_nettype none
`include "dsm_map.vh"

module dsm_ctrl #(
  parameter NPIN = 8,
  parameter ARB_W = 4
) (
  input wire mclk,
  input wire rst,
  // Module bus register port
  input wire bus_sel,
  input wire bus_wr,
  input wire [2:0] bus_addr,
  input wire [1:0] bus_be,
  input wire [15:0] bus_wdata,
  output reg [15:0] bus_rdata_q,
  output reg bus_ack_q,
  // Clock gate and freeze
  output wire module_clk_en,
  input wire freeze,
  input wire transfer_boundary,
  output reg queued_freeze_halt_q,
  // Interrupt requests and acknowledge
  input wire req_queued,
  input wire req_async,
  output reg [7:1] irq_lines_n_q,
  input wire iack_start,
  input wire [2:0] iack_level,
  input wire arb_in,
  output wire arb_out,
  output wire arb_oe,
  output wire [7:0] vec_data_q,
  output wire vec_oe_q,
  output wire arb_lost_q,
  // Pins and submodule hookup
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out_q,
  output reg [NPIN-1:0] pin_oe_q,
  input wire rxd_pin,
  output reg async_rxd_q,
  input wire queued_master,
  input wire [NPIN-2:0] queued_drive,
  output reg [NPIN-2:0] queued_pin_in_q,
  output reg [NPIN-2:0] queued_pin_ie_q,
  output reg queued_mode_fault_q,
  input wire async_tx_en,
  input wire async_txd
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg stop_q;
  reg [1:0] frz_q;
  reg [ARB_W-1:0] arbitration_priority_field_q;
  reg [2:0] lvl_queued_q;
  reg [2:0] lvl_async_q;
  reg [6:0] vec_hi_q;
  reg [NPIN-2:0] asg_q;
  reg [NPIN-1:0] dir_q;
  reg [NPIN-1:0] pdat_q;
  reg [15:0] rdata_d;
  reg [NPIN-1:0] out_d;
  reg [NPIN-1:0] oe_d;
  reg [NPIN-2:0] ie_d;

  wire wr_hi;
  wire wr_lo;
  wire rd;
  wire [NPIN-2:0] q_out_mask;
  wire [NPIN-2:0] q_in_mask;

  // One-hot request line for a three-bit level; zero selects none
  function [7:1] lvl_decode;
    input [2:0] lvl;
    integer k;
    begin
      for (k = 1; k <= 7; k = k + 1) begin
        lvl_decode[k] = (lvl == k[2:0]);
      end
    end
  endfunction

  assign wr_hi = bus_sel && bus_wr && bus_be[1];
  assign wr_lo = bus_sel && bus_wr && bus_be[0];
  assign rd = bus_sel && !bus_wr;

  // Our own logic keeps running so writes land while stopped
  assign module_clk_en = !stop_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Writes are accepted regardless of the stop bit
  always @(posedge mclk) begin
    if (rst) begin
      stop_q <= `DSM_CFG_STOP_RST;
      frz_q <= `DSM_CFG_FRZ_RST;
      arbitration_priority_field_q <= `DSM_CFG_ARBITRATION_PRIORITY_FIELD_RST;
      lvl_queued_q <= `DSM_LVL_RST;
      lvl_async_q <= `DSM_LVL_RST;
      vec_hi_q <= `DSM_VEC_RST;
      asg_q <= `DSM_ASG_RST;
      dir_q <= `DSM_DIR_RST;
      pdat_q <= `DSM_PDAT_RST;
    end else begin
      if (bus_addr == `DSM_IDX_CFG) begin
        if (wr_hi) begin
          stop_q <= bus_wdata[`DSM_CFG_STOP];
          frz_q <= bus_wdata[`DSM_CFG_FRZ_HI:`DSM_CFG_FRZ_LO];
        end
        if (wr_lo) begin
          arbitration_priority_field_q <= bus_wdata[`DSM_CFG_ARBITRATION_PRIORITY_FIELD_HI:`DSM_CFG_ARBITRATION_PRIORITY_FIELD_LO];
        end
      end else if (bus_addr == `DSM_IDX_INT) begin
        if (wr_hi) begin
          lvl_queued_q <= bus_wdata[`DSM_INT_ILQ_HI:`DSM_INT_ILQ_LO];
          lvl_async_q <= bus_wdata[`DSM_INT_ILS_HI:`DSM_INT_ILS_LO];
        end
        if (wr_lo) begin
          // Bit 0 of the vector is not stored
          vec_hi_q <= bus_wdata[`DSM_INT_VEC_HI:`DSM_INT_VEC_LO];
        end
      end else if (bus_addr == `DSM_IDX_PDAT) begin
        if (wr_lo) begin
          pdat_q <= bus_wdata[NPIN-1:0];
        end
      end else if (bus_addr == `DSM_IDX_PIN) begin
        if (wr_hi) begin
          asg_q <= bus_wdata[`DSM_PIN_ASG_HI:`DSM_PIN_ASG_LO];
        end
        if (wr_lo) begin
          dir_q <= bus_wdata[`DSM_PIN_DIR_HI:`DSM_PIN_DIR_LO];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 16'h0000;
    if (bus_addr == `DSM_IDX_CFG) begin
      rdata_d[`DSM_CFG_STOP] = stop_q;
      rdata_d[`DSM_CFG_FRZ_HI:`DSM_CFG_FRZ_LO] = frz_q;
      rdata_d[`DSM_CFG_ARBITRATION_PRIORITY_FIELD_HI:`DSM_CFG_ARBITRATION_PRIORITY_FIELD_LO] = arbitration_priority_field_q;
    end else if (stop_q) begin
      // Only the config word answers while stopped
      rdata_d = 16'h0000;
    end else if (bus_addr == `DSM_IDX_INT) begin
      rdata_d[`DSM_INT_ILQ_HI:`DSM_INT_ILQ_LO] = lvl_queued_q;
      rdata_d[`DSM_INT_ILS_HI:`DSM_INT_ILS_LO] = lvl_async_q;
      rdata_d[`DSM_INT_VEC_HI:`DSM_INT_VEC_LO] = vec_hi_q;
      rdata_d[0] = `DSM_VEC_READ_BIT0;
    end else if (bus_addr == `DSM_IDX_PDAT) begin
      rdata_d[NPIN-1:0] = pin_in;
    end else if (bus_addr == `DSM_IDX_PIN) begin
      rdata_d[`DSM_PIN_ASG_HI:`DSM_PIN_ASG_LO] = asg_q;
      rdata_d[`DSM_PIN_DIR_HI:`DSM_PIN_DIR_LO] = dir_q;
    end
  end

  // Every selected access is answered, unmapped ones with zero
  always @(posedge mclk) begin
    if (rst) begin
      bus_rdata_q <= 16'h0000;
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= bus_sel;
      if (rd) begin
        bus_rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Freeze response
  // ----------------------------------------------------------------
  // Lower freeze bit is stored but steers nothing
  always @(posedge mclk) begin
    if (rst) begin
      queued_freeze_halt_q <= 1'b0;
    end else if (!freeze) begin
      queued_freeze_halt_q <= 1'b0;
    end else if (frz_q[1] && transfer_boundary) begin
      queued_freeze_halt_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request lines
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      irq_lines_n_q <= 7'h7F;
    end else begin
      irq_lines_n_q <= ~((lvl_decode(lvl_queued_q) & {7{req_queued}}) |
                         (lvl_decode(lvl_async_q) & {7{req_async}}));
    end
  end

  dsm_iack_arb #(
    .ARB_W(ARB_W)
  ) u_arb (
    .mclk(mclk),
    .rst(rst),
    .arbitration_priority_field(arbitration_priority_field_q),
    .vec_hi(vec_hi_q),
    .lvl_queued(lvl_queued_q),
    .lvl_async(lvl_async_q),
    .req_queued(req_queued),
    .req_async(req_async),
    .iack_start(iack_start),
    .iack_level(iack_level),
    .arb_in(arb_in),
    .arb_out(arb_out),
    .arb_oe(arb_oe),
    .vec_data_q(vec_data_q),
    .vec_oe_q(vec_oe_q),
    .arb_lost_q(arb_lost_q)
  );

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------
  assign q_out_mask = queued_master ? `DSM_MASK_MOUT : `DSM_MASK_SOUT;
  assign q_in_mask = queued_master ? `DSM_MASK_MIN : `DSM_MASK_SIN;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN - 1; gi = gi + 1) begin : g_pin
      always @* begin
        if (asg_q[gi]) begin
          // Queued port owns the pin; direction gates its role
          out_d[gi] = queued_drive[gi];
          oe_d[gi] = dir_q[gi] && q_out_mask[gi];
          ie_d[gi] = !dir_q[gi] && q_in_mask[gi];
        end else begin
          out_d[gi] = pdat_q[gi];
          oe_d[gi] = dir_q[gi];
          ie_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // Enabled transmitter overrides the direction bit
  always @* begin
    out_d[`DSM_PIN_TXD] = async_tx_en ? async_txd : pdat_q[`DSM_PIN_TXD];
    oe_d[`DSM_PIN_TXD] = async_tx_en || dir_q[`DSM_PIN_TXD];
  end

  always @(posedge mclk) begin
    if (rst) begin
      pin_out_q <= {NPIN{1'b0}};
      pin_oe_q <= {NPIN{1'b0}};
      queued_pin_in_q <= {(NPIN-1){1'b0}};
      queued_pin_ie_q <= {(NPIN-1){1'b0}};
      queued_mode_fault_q <= 1'b0;
      async_rxd_q <= 1'b1;
    end else begin
      pin_out_q <= out_d;
      pin_oe_q <= oe_d;
      queued_pin_ie_q <= ie_d;
      queued_pin_in_q <= pin_in[NPIN-2:0] & ie_d;
      // Receive pin has no direction or assignment
      async_rxd_q <= rxd_pin;
      // Select input low in master mode with direction clear
      queued_mode_fault_q <= queued_master && asg_q[`DSM_PIN_SEL] &&
                             !dir_q[`DSM_PIN_SEL] && !pin_in[`DSM_PIN_SEL];
    end
  end

endmodule // dsm_ctrl
`default_nettype wire

// [dsm_ctrl_assertions.sv]
// Port-level checker for the dual serial module control block
`timescale 1ns/10ps
`default_nettype none
module dsm_ctrl_checker #(
  parameter NPIN = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [2:0] bus_addr,
  input wire logic [15:0] bus_rdata_q,
  input wire logic bus_ack_q,
  input wire logic module_clk_en,
  input wire logic freeze,
  input wire logic queued_freeze_halt_q,
  input wire logic req_queued,
  input wire logic req_async,
  input wire logic [7:1] irq_lines_n_q,
  input wire logic vec_oe_q,
  input wire logic arb_lost_q,
  input wire logic [NPIN-1:0] pin_out_q,
  input wire logic [NPIN-1:0] pin_oe_q,
  input wire logic async_tx_en,
  input wire logic async_txd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_per_access: assert property (bus_sel |=> bus_ack_q) else $error("no ack after access");
  a_no_stray_ack: assert property (!bus_sel |=> !bus_ack_q) else $error("ack without access");
  a_unmapped_zero: assert property (bus_sel && !bus_wr && (bus_addr inside {3'h1, 3'h3, 3'h6, 3'h7})
    |=> bus_rdata_q == 16'h0000) else $error("unmapped read not zero");
  a_stop_read_zero: assert property (bus_sel && !bus_wr && bus_addr != 3'h0 && !module_clk_en
    |=> bus_rdata_q == 16'h0000) else $error("stopped read not zero");
  a_vec_bit0_one: assert property (bus_sel && !bus_wr && bus_addr == 3'h2 && module_clk_en
    |=> bus_rdata_q[0]) else $error("vector bit 0 not one");
  a_reset_stops: assert property (disable iff (1'b0) rst |=> !module_clk_en) else $error("clock runs after reset");
  a_freeze_release: assert property (!freeze |=> !queued_freeze_halt_q) else $error("halt without freeze");
  a_txd_forced: assert property (async_tx_en |=> pin_oe_q[NPIN-1] && pin_out_q[NPIN-1] == $past(async_txd))
    else $error("transmit pin not forced");
  a_idle_no_irq: assert property ((!req_queued && !req_async) [*2] |=> irq_lines_n_q == 7'h7F)
    else $error("request line without request");
  a_lost_no_vec: assert property (arb_lost_q |-> !vec_oe_q) else $error("vector after loss");
  a_vec_pulse: assert property (vec_oe_q |=> !vec_oe_q) else $error("vector longer than a cycle");
endmodule // dsm_ctrl_checker
bind dsm_ctrl dsm_ctrl_checker #(.NPIN(NPIN)) u_chk (.mclk(mclk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr),
  .bus_addr(bus_addr), .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q), .module_clk_en(module_clk_en),
  .freeze(freeze), .queued_freeze_halt_q(queued_freeze_halt_q), .req_queued(req_queued), .req_async(req_async),
  .irq_lines_n_q(irq_lines_n_q), .vec_oe_q(vec_oe_q), .arb_lost_q(arb_lost_q), .pin_out_q(pin_out_q),
  .pin_oe_q(pin_oe_q), .async_tx_en(async_tx_en), .async_txd(async_txd));
`default_nettype wire

// [dsm_ctrl_tb_top.sv]
// Self-checking testbench of the dual serial module control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("Error at %0t: got %h want %h", $time, a, b); end end
module dsm_ctrl_tb_top;
  logic mclk = 1'b0, rst = 1'b1, freeze = 1'b0, tb_q = 1'b0, req_q = 1'b0, req_a = 1'b0;
  logic iack_start = 1'b0, rival_on = 1'b0, master = 1'b0, tx_en = 1'b0, txd = 1'b0, seen_v, seen_l;
  logic rxd = 1'b1;
  wire rxq, mf;
  wire [6:0] qpi;
  logic [2:0] iack_level = 3'h0;
  logic [7:0] pin_in = 8'h00, vdat;
  logic [15:0] rd;
  int fails = 0, comparisons = 0;
  wire bus_sel, bus_wr, bus_ack_q, clk_en, halt, arb_in, arb_out, arb_oe, vec_oe_q, lost;
  wire [2:0] bus_addr;
  wire [1:0] bus_be;
  wire [15:0] bus_wdata, bus_rdata_q;
  wire [7:1] irq_n;
  wire [7:0] vec_data_q, pin_out_q, pin_oe_q;
  wire [6:0] qie;
  dsm_host_model u_host (.mclk(mclk), .rival_on(rival_on), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .iack_start(iack_start), .arb_out(arb_out),
    .arb_oe(arb_oe), .arb_in(arb_in));
  dsm_ctrl u_dut (.mclk(mclk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q), .module_clk_en(clk_en),
    .freeze(freeze), .transfer_boundary(tb_q), .queued_freeze_halt_q(halt), .req_queued(req_q), .req_async(req_a),
    .irq_lines_n_q(irq_n), .iack_start(iack_start), .iack_level(iack_level), .arb_in(arb_in), .arb_out(arb_out),
    .arb_oe(arb_oe), .vec_data_q(vec_data_q), .vec_oe_q(vec_oe_q), .arb_lost_q(lost), .pin_in(pin_in),
    .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .rxd_pin(rxd), .async_rxd_q(rxq), .queued_master(master),
    .queued_drive(7'h00), .queued_pin_in_q(qpi), .queued_pin_ie_q(qie), .queued_mode_fault_q(mf),
    .async_tx_en(tx_en), .async_txd(txd));
  always #2 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdr(input logic [2:0] a);
    u_host.xfer(1'b0, a, 16'h0000, rd);
  endtask
  task automatic iack(input logic [2:0] lv);
    seen_v = 1'b0;
    seen_l = 1'b0;
    iack_level = lv;
    iack_start = 1'b1;
    tick(1);
    iack_start = 1'b0;
    repeat (10) begin
      if (vec_oe_q === 1'b1) begin
        seen_v = 1'b1;
        vdat = vec_data_q;
      end
      if (lost === 1'b1) seen_l = 1'b1;
      tick(1);
    end
  endtask
  task automatic t_regs;
    rdr(3'h0); `CHK(rd, 16'h8000)
    `CHK(clk_en, 1'b0)
    rdr(3'h2); `CHK(rd, 16'h0000)
    wr(3'h0, 16'h0001);
    rdr(3'h2); `CHK(rd, 16'h000F)
    // Ports are idle here, so stop may be set
    wr(3'h0, 16'h8001);
    wr(3'h2, 16'h1B40);
    wr(3'h0, 16'h6F0F);
    rdr(3'h0); `CHK(rd, 16'h600F)
    `CHK(clk_en, 1'b1)
    rdr(3'h2); `CHK(rd, 16'h1B41)
    rdr(3'h6); `CHK(rd, 16'h0000)
    $display("test regs done");
  endtask
  task automatic t_irq;
    logic [6:0] e;
    req_a = 1'b1;
    for (int l = 0; l < 8; l++) begin
      wr(3'h2, {5'h00, l[2:0], 8'h40});
      tick(3);
      e = (l == 0) ? 7'h7F : ~(7'h01 << (l - 1));
      `CHK(irq_n, e)
    end
    wr(3'h0, 16'h0001);
    wr(3'h2, 16'h1B40);
    req_q = 1'b1;
    tick(3);
    `CHK(irq_n, 7'h7B)
    iack(3'h3); `CHK({seen_v, vdat}, 9'h141)
    req_q = 1'b0;
    tick(3);
    iack(3'h3); `CHK({seen_v, vdat}, 9'h140)
    iack(3'h5); `CHK({seen_v, seen_l}, 2'h0)
    rival_on = 1'b1;
    iack(3'h3); `CHK({seen_v, seen_l}, 2'h1)
    rival_on = 1'b0;
    req_a = 1'b0;
    $display("test irq done");
  endtask
  task automatic t_pins;
    // Latch first so the reset value 8'h00 of the data latch is never driven
    wr(3'h4, 16'h00A5);
    wr(3'h5, 16'h00FF);
    tick(2);
    `CHK({pin_oe_q, pin_out_q}, 16'hFFA5)
    pin_in = 8'h3C;
    rdr(3'h4); `CHK(rd, 16'h003C)
    master = 1'b1;
    wr(3'h5, 16'h7F7F);
    tick(2);
    `CHK(pin_oe_q[6:0], 7'h7E)
    wr(3'h5, 16'h7F00);
    tick(2);
    `CHK(qie, 7'h09)
    pin_in = 8'h35;
    rxd = 1'b0;
    tick(2);
    `CHK({mf, rxq, qpi}, 9'h101)
    pin_in = 8'h3C;
    rxd = 1'b1;
    master = 1'b0;
    wr(3'h5, 16'h7F7F);
    tick(2);
    `CHK(pin_oe_q[6:0], 7'h01)
    tx_en = 1'b1;
    txd = 1'b1;
    wr(3'h5, 16'h7F00);
    tick(2);
    `CHK({pin_oe_q[7], pin_out_q[7]}, 2'h3)
    $display("test pins done");
  endtask
  task automatic frz(input logic [15:0] cfg, input logic e);
    wr(3'h0, cfg);
    freeze = 1'b1;
    tb_q = 1'b1;
    tick(1);
    tb_q = 1'b0;
    tick(1);
    `CHK(halt, e)
    freeze = 1'b0;
    tick(2);
    `CHK(halt, 1'b0)
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_regs;
    t_irq;
    t_pins;
    frz(16'h4001, 1'b1);
    frz(16'h2001, 1'b0);
    $display("test freeze done");
    print_verdict;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
endmodule // dsm_ctrl_tb_top
`default_nettype wire

// [dsm_host_model.sv]
// Host bus master and rival interrupter facing the dual serial module
`timescale 1ns/10ps
`default_nettype none
module dsm_host_model (
  input wire logic mclk,
  input wire logic rival_on,
  output logic bus_sel,
  output logic bus_wr,
  output logic [2:0] bus_addr,
  output logic [1:0] bus_be,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata_q,
  input wire logic iack_start,
  input wire logic arb_out,
  input wire logic arb_oe,
  output logic arb_in
);
  logic [3:0] rival_cnt_q;
  initial begin
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 3'h0;
    bus_be = 2'h0;
    bus_wdata = 16'h0000;
    rival_cnt_q = 4'h0;
  end
  // Rival holds priority 4'hF: drives one over every slot of the contest
  always @(posedge mclk) begin
    if (iack_start && rival_on) begin
      rival_cnt_q <= 4'h6;
    end else if (rival_cnt_q != 4'h0) begin
      rival_cnt_q <= rival_cnt_q - 4'h1;
    end
  end
  assign arb_in = (arb_oe & arb_out) | (rival_cnt_q != 4'h0);
  task automatic xfer(input logic wr, input logic [2:0] addr, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge mclk);
    #1;
    bus_sel = 1'b1;
    bus_wr = wr;
    bus_addr = addr;
    bus_be = 2'h3;
    bus_wdata = wd;
    @(posedge mclk);
    #1;
    bus_sel = 1'b0;
    // Released lines must not keep showing stale data
    bus_wdata = ~wd;
    bus_addr = ~addr;
    rd = bus_rdata_q;
  endtask
endmodule // dsm_host_model
`default_nettype wire

// [dsm_iack_arb.v]
// Interrupt acknowledge contention, serial arbitration and vector drive
`timescale 1ns/10ps
`default_nettype none
`include "dsm_map.vh"

module dsm_iack_arb #(
  parameter ARB_W = 4
) (
  input wire mclk,
  input wire rst,
  input wire [ARB_W-1:0] arbitration_priority_field,
  input wire [6:0] vec_hi,
  input wire [2:0] lvl_queued,
  input wire [2:0] lvl_async,
  input wire req_queued,
  input wire req_async,
  input wire iack_start,
  input wire [2:0] iack_level,
  input wire arb_in,
  output reg arb_out,
  output reg arb_oe,
  output reg [7:0] vec_data_q,
  output reg vec_oe_q,
  output reg arb_lost_q
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ARB = 2'd1;
  localparam ST_VEC = 2'd2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [ARB_W-1:0] bit_q;
  reg src_q;
  wire hit_q;
  wire hit_s;
  wire my_bit;

  // ----------------------------------------------------------------
  // Contention decision
  // ----------------------------------------------------------------
  assign hit_q = req_queued && (lvl_queued != `DSM_LVL_OFF) && (lvl_queued == iack_level);
  assign hit_s = req_async && (lvl_async != `DSM_LVL_OFF) && (lvl_async == iack_level);
  assign my_bit = |(arbitration_priority_field & bit_q);

  // Open-drain style: drive only the ones of the field
  always @* begin
    arb_out = 1'b0;
    arb_oe = 1'b0;
    if (state_q == ST_ARB) begin
      arb_out = my_bit;
      arb_oe = my_bit;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // Zero field never contends: it would vanish on the wired line
        if (iack_start && (hit_q || hit_s) && (arbitration_priority_field != {ARB_W{1'b0}})) begin
          state_d = ST_ARB;
        end
      end
      ST_ARB: begin
        if (!my_bit && arb_in) begin
          state_d = ST_IDLE;
        end else if (bit_q[0]) begin
          state_d = ST_VEC;
        end
      end
      ST_VEC: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_q <= {ARB_W{1'b0}};
      src_q <= `DSM_VEC_SRC_ASYNC;
      vec_data_q <= 8'h00;
      vec_oe_q <= 1'b0;
      arb_lost_q <= 1'b0;
    end else begin
      state_q <= state_d;
      vec_oe_q <= 1'b0;
      arb_lost_q <= 1'b0;
      if (state_q == ST_IDLE) begin
        bit_q <= {1'b1, {(ARB_W-1){1'b0}}};
        // Queued port wins a tie at the same level
        src_q <= hit_q ? `DSM_VEC_SRC_QUEUED : `DSM_VEC_SRC_ASYNC;
      end else if (state_q == ST_ARB) begin
        bit_q <= bit_q >> 1;
        if (!my_bit && arb_in) begin
          arb_lost_q <= 1'b1;
        end
        if (state_d == ST_VEC) begin
          vec_data_q <= {vec_hi, src_q};
          vec_oe_q <= 1'b1;
        end
      end
    end
  end

endmodule // dsm_iack_arb
`default_nettype wire

// [dsm_map.vh]
// Register map, field layout and reset values of the dual serial module control block
`ifndef DSM_MAP_VH
`define DSM_MAP_VH

// ----------------------------------------------------------------
// Word indices on the module bus
// ----------------------------------------------------------------
`define DSM_IDX_CFG 3'h0
`define DSM_IDX_INT 3'h2
`define DSM_IDX_PDAT 3'h4
`define DSM_IDX_PIN 3'h5

// ----------------------------------------------------------------
// Module config register fields
// ----------------------------------------------------------------
`define DSM_CFG_STOP 15
`define DSM_CFG_FRZ_HI 14
`define DSM_CFG_FRZ_LO 13
`define DSM_CFG_ARBITRATION_PRIORITY_FIELD_HI 3
`define DSM_CFG_ARBITRATION_PRIORITY_FIELD_LO 0
`define DSM_CFG_STOP_RST 1'h1
`define DSM_CFG_FRZ_RST 2'h0
`define DSM_CFG_ARBITRATION_PRIORITY_FIELD_RST 4'h0

// ----------------------------------------------------------------
// Interrupt word: level select high byte, vector low byte
// ----------------------------------------------------------------
`define DSM_INT_ILQ_HI 13
`define DSM_INT_ILQ_LO 11
`define DSM_INT_ILS_HI 10
`define DSM_INT_ILS_LO 8
`define DSM_INT_VEC_HI 7
`define DSM_INT_VEC_LO 1
`define DSM_LVL_RST 3'h0
`define DSM_VEC_RST 7'h07
`define DSM_LVL_OFF 3'h0
`define DSM_VEC_SRC_ASYNC 1'h0
`define DSM_VEC_SRC_QUEUED 1'h1
`define DSM_VEC_READ_BIT0 1'h1

// ----------------------------------------------------------------
// Pin word: assignment high byte, direction low byte
// ----------------------------------------------------------------
`define DSM_PIN_ASG_HI 14
`define DSM_PIN_ASG_LO 8
`define DSM_PIN_DIR_HI 7
`define DSM_PIN_DIR_LO 0
`define DSM_ASG_RST 7'h00
`define DSM_DIR_RST 8'h00
`define DSM_PDAT_RST 8'h00
`define DSM_PIN_TXD 7
`define DSM_PIN_SEL 3
// Queued-port pins that drive in master and in slave mode
`define DSM_MASK_MOUT 7'h7E
`define DSM_MASK_SOUT 7'h01
// Queued-port pins that receive in master and in slave mode
`define DSM_MASK_MIN 7'h09
`define DSM_MASK_SIN 7'h0E

`endif
